// >>> mrd_regs.svh
// Register offsets, field positions, reset values and constants of the receive DMA block
`ifndef MRD_REGS_SVH
`define MRD_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MRD_OFF_CTRL      12'h000
`define MRD_OFF_TX_BUFFER_START_POINTER      12'h004
`define MRD_OFF_BP        12'h008
`define MRD_OFF_RX_BUFFER_UPPER_BOUND      12'h00c
`define MRD_OFF_BUFSIZE   12'h010
`define MRD_OFF_RRP       12'h014
`define MRD_OFF_RWP       12'h018
`define MRD_OFF_BLKS      12'h01c
`define MRD_OFF_FLAGS     12'h020
`define MRD_WIN_BIT       11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MRD_RST_TX_BUFFER_START_POINTER      24'h000000
`define MRD_RST_BP        24'h000400
`define MRD_RST_RX_BUFFER_UPPER_BOUND      24'h000800
`define MRD_RST_BUFSIZE   8'h00

// ----------------------------------------------------------------
// Interrupt flag bit positions
// ----------------------------------------------------------------
`define MRD_FLG_TX_DONE   0
`define MRD_FLG_TX_CF     1
`define MRD_FLG_RX_OVR    2
`define MRD_FLG_RX_DONE   3
`define MRD_FLG_RX_PCF    4
`define MRD_FLG_RX_PKT    5
`define MRD_FLG_MGT_DONE  6
`define MRD_FLG_TX_FSM    7

// ----------------------------------------------------------------
// Receive condition word bits and frame constants
// ----------------------------------------------------------------
`define MRD_ST_OK         15
`define MRD_ST_ALIGN      14
`define MRD_ST_PCF        11
`define MRD_ST_CF         10
`define MRD_ST_MC         9
`define MRD_ST_BC         8
`define MRD_DESC_BYTES    4'd7
`define MRD_MEM_AW        11
`define MRD_SFD_NIB       4'hd
`define MRD_CTL_TYPE_HI   8'h88
`define MRD_CTL_TYPE_LO   8'h08
`define MRD_PAUSE_OP_HI   8'h00
`define MRD_PAUSE_OP_LO   8'h01

`endif

// >>> mrd_pkg.sv
// Types shared by the receive DMA block
`default_nettype none
package mrd_pkg;
  // Nibble assembly states of the receive link
  typedef enum logic [1:0] {MII_IDLE, MII_LOW, MII_HIGH} mrd_mii_state_type;
  // Receive DMA states
  typedef enum logic [3:0] {
    DMA_IDLE, DMA_DATA, DMA_STAT_LO, DMA_STAT_HI, DMA_LEN_LO, DMA_LEN_HI, DMA_NP0, DMA_NP1, DMA_NP2
  } mrd_dma_state_type;
endpackage
`default_nettype wire

// >>> mrd_byte_mem.sv
// Shared Ethernet byte memory with one write port and one registered read port
`default_nettype none
`include "mrd_regs.svh"
module mrd_byte_mem (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    we,
  input  wire logic [`MRD_MEM_AW-1:0]  waddr,
  input  wire logic [7:0]              wdata,
  input  wire logic [`MRD_MEM_AW-1:0]  raddr,
  output var  logic [7:0]              rdata
);
  logic [7:0] mem_q [0:(1<<`MRD_MEM_AW)-1];

  // Byte write from the DMA
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Registered read for the bus window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// >>> mrd_rx_dma.sv
// Receive DMA, shared memory partition and interrupt flags of the 10/100 MAC
//
// Local design decisions: the APB interface to the registers and the register addresses.
`default_nettype none
`include "mrd_regs.svh"

// Operation
// (RULE_01) After frame end, the two following bytes become condition word low, high.
// (RULE_02) Closing writes length and next link into descriptor, sets receive-done flag.
// (RULE_03) Flag bit 7 reports transmit state machine fault; software resets transmitter.
// (RULE_04) Flag bit 6 reports a finished PHY management read or write.
// (RULE_05) While overrun flag bit 2 is set, every incoming frame is discarded.
// (RULE_06) Flag bit 1 sets when a control frame has been sent.
// (RULE_07) Flag bit 0 sets when an ordinary packet has been sent.
// (RULE_08) Bit 5 packet received, bit 4 pause received, bit 3 receive done.
// (RULE_09) With the MAC unused, management data and clock pins are not driven.
// (RULE_10) Receive valid, error and data are taken on receive clock rising edges.
// (RULE_11) Transmit enable, error and data change on transmit clock rising edges.
// (RULE_12) Three pointers split memory: transmit start, receive start, receive end plus one.
// (RULE_13) Packet buffers are 32, 64, 128 or 256 bytes, set by size bits 7:6.
// (RULE_14) One frame may span several consecutive packet buffers.
// (RULE_15) Each stored packet starts with its descriptor, frame bytes right after.
// (RULE_16) Descriptor holds next link, byte count and condition word only.
// (RULE_17) Next link is a 24-bit address of the following descriptor.
// (RULE_18) Byte count includes the four check bytes, excludes the seven descriptor bytes.
// (RULE_19) Condition word meaning differs between sent and received packets.
// (RULE_20) Free packet buffers follow from hardware write and software read pointers.
// (RULE_21) Condition bit 15 is set only for a frame received intact.
// (RULE_22) Descriptor little-endian: three link bytes, two count bytes, two condition bytes.
// (RULE_23) Size codes 00, 01, 10, 11 give 256, 128, 64, 32 byte buffers.
module mrd_rx_dma
  import mrd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_clk,
  input  wire logic        rx_dv,
  input  wire logic        rx_er,
  input  wire logic [3:0]  rxd,
  input  wire logic        tx_clk,
  output var  logic        tx_en,
  output var  logic        tx_er,
  output var  logic [3:0]  txd,
  input  wire logic        mdio_i,
  output var  logic        mdio_o,
  output var  logic        mdio_oe,
  output var  logic        mdc_o,
  output var  logic        mdc_oe,
  input  wire logic        tx_done_evt,
  input  wire logic        tx_cf_evt,
  input  wire logic        tx_fsm_err_evt,
  input  wire logic        mgmt_done_evt
);

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  // Packet buffer size as a shift count
  function automatic logic [3:0] buf_shift(input logic [1:0] code);
    unique case (code)
      2'b00: buf_shift = 4'd8;
      2'b01: buf_shift = 4'd7;
      2'b10: buf_shift = 4'd6;
      2'b11: buf_shift = 4'd5;
    endcase
  endfunction

  // Advance a pointer inside the receive ring, wrapping at its upper bound
  function automatic logic [23:0] ptr_add(input logic [23:0] a, input logic [3:0] n,
                                          input logic [23:0] lo, input logic [23:0] hi);
    logic [24:0] s;
    s = {1'b0, a} + {21'h000000, n};
    if (s >= {1'b0, hi}) begin
      s = s - {1'b0, hi} + {1'b0, lo};
    end
    return s[23:0];
  endfunction

  // Round a pointer up to the next packet buffer boundary
  function automatic logic [23:0] round_up(input logic [23:0] a, input logic [23:0] lo,
                                           input logic [23:0] hi, input logic [1:0] code);
    logic [23:0] mask;
    logic [23:0] off;
    logic [23:0] r;
    mask = (24'h000001 << buf_shift(code)) - 24'h000001; // [RULE_23]
    off  = ((a - lo) + mask) & ~mask;
    r    = lo + off;
    if (r >= hi) begin
      r = lo;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------
  logic        ctrl_en_q;
  logic [23:0] tx_buffer_start_pointer_q, bp_q, rx_buffer_upper_bound_q, rrp_q, wp_q, desc_q, ptr_q, np_q;
  logic [7:0]  bufsize_q, flags_q, flg_set, flg_clr;
  logic [31:0] rd_mux;
  logic        rd_err, win_sel, acc_first, wr_go, bp_wr;
  logic        ready_q, slverr_q;
  logic [31:0] prdata_q;
  logic [7:0]  sync1_q, sync2_q, sync3_q, filt_q, filt_d, filt_prev_q;
  logic        rx_rise, tx_rise;
  mrd_mii_state_type mii_q;
  logic [3:0]  lo_nib_q;
  logic        er_q, byte_vld_q, start_q, end_q, align_q;
  logic [7:0]  byte_q;
  logic [4:0]  idx_q;
  logic        bc_q, mc_q, cf_hi_q, cf_q, op_hi_q, pcf_q;
  logic [15:0] stat_q, cnt_q;
  mrd_dma_state_type dma_q;
  logic        drop_q, done_q, ovr_q;
  logic        mem_we_q;
  logic [`MRD_MEM_AW-1:0] mem_wa_q;
  logic [7:0]  mem_wd_q, mem_rd;
  logic [23:0] used_w, free_w, ptr_nx, np_w;
  logic        tx_en_q, tx_er_q, mdio_o_q, mdio_oe_q, mdc_o_q, mdc_oe_q;
  logic [3:0]  txd_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign win_sel   = paddr[`MRD_WIN_BIT];
  assign acc_first = psel & penable & ~ready_q;
  assign wr_go     = psel & penable & ready_q & pwrite & ~slverr_q;
  assign bp_wr     = wr_go & (paddr == `MRD_OFF_BP);

  // Read mux and address decode
  always_comb begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (win_sel) begin
      rd_mux = {24'h000000, mem_rd};
      rd_err = pwrite;
    end else begin
      unique case (paddr)
        `MRD_OFF_CTRL:    rd_mux = {31'h00000000, ctrl_en_q};
        `MRD_OFF_TX_BUFFER_START_POINTER:    rd_mux = {8'h00, tx_buffer_start_pointer_q};
        `MRD_OFF_BP:      rd_mux = {8'h00, bp_q};
        `MRD_OFF_RX_BUFFER_UPPER_BOUND:    rd_mux = {8'h00, rx_buffer_upper_bound_q};
        `MRD_OFF_BUFSIZE: rd_mux = {24'h000000, bufsize_q};
        `MRD_OFF_RRP:     rd_mux = {8'h00, rrp_q};
        `MRD_OFF_RWP:     rd_mux = {8'h00, wp_q};
        `MRD_OFF_BLKS:    rd_mux = {8'h00, free_w};
        `MRD_OFF_FLAGS:   rd_mux = {24'h000000, flags_q};
        default:          rd_err = 1'b1;
      endcase
    end
  end

  // One wait state on every transfer, answer from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      ready_q  <= acc_first;
      slverr_q <= acc_first & rd_err;
      if (acc_first & ~pwrite & ~rd_err) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_q <= 1'b0;
      tx_buffer_start_pointer_q    <= `MRD_RST_TX_BUFFER_START_POINTER;
      bp_q      <= `MRD_RST_BP;
      rx_buffer_upper_bound_q    <= `MRD_RST_RX_BUFFER_UPPER_BOUND;
      bufsize_q <= `MRD_RST_BUFSIZE;
      rrp_q     <= `MRD_RST_BP;
    end else if (wr_go) begin
      unique case (paddr)
        `MRD_OFF_CTRL:    ctrl_en_q <= pwdata[0];
        `MRD_OFF_TX_BUFFER_START_POINTER:    tx_buffer_start_pointer_q    <= pwdata[23:0]; // [RULE_12]
        `MRD_OFF_BP:      bp_q      <= pwdata[23:0]; // [RULE_12]
        `MRD_OFF_RX_BUFFER_UPPER_BOUND:    rx_buffer_upper_bound_q    <= pwdata[23:0]; // [RULE_12]
        `MRD_OFF_BUFSIZE: bufsize_q <= pwdata[7:0];  // [RULE_13]
        `MRD_OFF_RRP:     rrp_q     <= pwdata[23:0];
        default:          ;
      endcase
    end
  end

  // Free packet buffers between write and read pointers
  assign used_w = (wp_q >= rrp_q) ? (wp_q - rrp_q) : ((rx_buffer_upper_bound_q - bp_q) - (rrp_q - wp_q));
  assign free_w = ((rx_buffer_upper_bound_q - bp_q) - used_w) >> buf_shift(bufsize_q[7:6]); // [RULE_20]

  // Interrupt flags: write one to clear, a new event wins over the clear
  always_comb begin
    flg_set = 8'h00;
    flg_set[`MRD_FLG_TX_DONE]  = tx_done_evt;    // [RULE_07]
    flg_set[`MRD_FLG_TX_CF]    = tx_cf_evt;      // [RULE_06]
    flg_set[`MRD_FLG_RX_OVR]   = ovr_q;
    flg_set[`MRD_FLG_RX_DONE]  = done_q;         // [RULE_08]
    flg_set[`MRD_FLG_RX_PCF]   = done_q & pcf_q; // [RULE_08]
    flg_set[`MRD_FLG_RX_PKT]   = done_q;         // [RULE_08]
    flg_set[`MRD_FLG_MGT_DONE] = mgmt_done_evt;  // [RULE_04]
    flg_set[`MRD_FLG_TX_FSM]   = tx_fsm_err_evt; // [RULE_03]
    flg_clr = (wr_go && paddr == `MRD_OFF_FLAGS) ? pwdata[7:0] : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= (flags_q & ~flg_clr) | flg_set;
    end
  end

  // ----------------------------------------------------------------
  // Link pin synchronisers and edge detection
  // ----------------------------------------------------------------
  // A bit changes once the second and third stages agree
  assign filt_d = (sync3_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q     <= 8'h00;
      sync2_q     <= 8'h00;
      sync3_q     <= 8'h00;
      filt_q      <= 8'h00;
      filt_prev_q <= 8'h00;
    end else begin
      sync1_q     <= {tx_clk, rx_clk, rx_dv, rx_er, rxd};
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      filt_q      <= filt_d;
      filt_prev_q <= filt_q;
    end
  end

  assign rx_rise = filt_q[6] & ~filt_prev_q[6]; // [RULE_10]
  assign tx_rise = filt_q[7] & ~filt_prev_q[7]; // [RULE_11]

  // ----------------------------------------------------------------
  // Receive nibble assembly
  // ----------------------------------------------------------------
  // Receive inputs act only on a receive clock rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_q      <= MII_IDLE;
      lo_nib_q   <= 4'h0;
      er_q       <= 1'b0;
      align_q    <= 1'b0;
      byte_q     <= 8'h00;
      byte_vld_q <= 1'b0;
      start_q    <= 1'b0;
      end_q      <= 1'b0;
    end else begin
      byte_vld_q <= 1'b0;
      start_q    <= 1'b0;
      end_q      <= 1'b0;
      if (rx_rise) begin // [RULE_10]
        unique case (mii_q)
          MII_IDLE: begin
            if (filt_q[5] && filt_q[3:0] == `MRD_SFD_NIB) begin
              mii_q   <= MII_LOW;
              er_q    <= 1'b0;
              start_q <= 1'b1;
            end
          end
          MII_LOW: begin
            er_q <= er_q | filt_q[4];
            if (!filt_q[5]) begin
              mii_q   <= MII_IDLE;
              align_q <= 1'b0;
              end_q   <= 1'b1;
            end else begin
              lo_nib_q <= filt_q[3:0];
              mii_q    <= MII_HIGH;
            end
          end
          MII_HIGH: begin
            er_q <= er_q | filt_q[4];
            if (!filt_q[5]) begin
              mii_q   <= MII_IDLE;
              align_q <= 1'b1;
              end_q   <= 1'b1;
            end else begin
              byte_q     <= {filt_q[3:0], lo_nib_q};
              byte_vld_q <= 1'b1;
              mii_q      <= MII_LOW;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame classification for the receive condition word
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q   <= 5'd0;
      bc_q    <= 1'b0;
      mc_q    <= 1'b0;
      cf_hi_q <= 1'b0;
      cf_q    <= 1'b0;
      op_hi_q <= 1'b0;
      pcf_q   <= 1'b0;
    end else if (start_q) begin
      idx_q   <= 5'd0;
      bc_q    <= 1'b0;
      mc_q    <= 1'b0;
      cf_q    <= 1'b0;
      pcf_q   <= 1'b0;
    end else if (byte_vld_q) begin
      if (idx_q != 5'd16) begin
        idx_q <= idx_q + 5'd1;
      end
      unique case (idx_q)
        5'd0:                     begin bc_q <= (byte_q == 8'hff); mc_q <= byte_q[0]; end
        5'd1, 5'd2, 5'd3, 5'd4, 5'd5: bc_q <= bc_q & (byte_q == 8'hff);
        5'd12:                    cf_hi_q <= (byte_q == `MRD_CTL_TYPE_HI);
        5'd13:                    cf_q    <= cf_hi_q & (byte_q == `MRD_CTL_TYPE_LO);
        5'd14:                    op_hi_q <= (byte_q == `MRD_PAUSE_OP_HI);
        5'd15:                    pcf_q   <= cf_q & op_hi_q & (byte_q == `MRD_PAUSE_OP_LO);
        default:                  ;
      endcase
    end
  end

  // Receive condition word, bit 15 only for an intact frame
  always_comb begin
    stat_q                = 16'h0000;
    stat_q[`MRD_ST_OK]    = ~er_q & ~align_q; // [RULE_21] [RULE_19]
    stat_q[`MRD_ST_ALIGN] = align_q;
    stat_q[`MRD_ST_PCF]   = pcf_q;
    stat_q[`MRD_ST_CF]    = cf_q;
    stat_q[`MRD_ST_MC]    = mc_q & ~bc_q;
    stat_q[`MRD_ST_BC]    = bc_q;
  end

  // ----------------------------------------------------------------
  // Receive DMA
  // ----------------------------------------------------------------
  // Descriptor byte address in the shared memory, wrapped inside the ring
  function automatic logic [`MRD_MEM_AW-1:0] desc_addr(input logic [3:0] n);
    logic [23:0] p;
    p = ptr_add(desc_q, n, bp_q, rx_buffer_upper_bound_q);
    return p[`MRD_MEM_AW-1:0];
  endfunction

  assign ptr_nx = ptr_add(ptr_q, 4'd1, bp_q, rx_buffer_upper_bound_q);
  assign np_w   = round_up(ptr_q, bp_q, rx_buffer_upper_bound_q, bufsize_q[7:6]); // [RULE_14]

  // Descriptor first, frame bytes after, descriptor closed at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_q    <= DMA_IDLE;
      wp_q     <= `MRD_RST_BP;
      desc_q   <= 24'h000000;
      ptr_q    <= 24'h000000;
      np_q     <= 24'h000000;
      cnt_q    <= 16'h0000;
      drop_q   <= 1'b0;
      done_q   <= 1'b0;
      ovr_q    <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wa_q <= '0;
      mem_wd_q <= 8'h00;
    end else begin
      mem_we_q <= 1'b0;
      done_q   <= 1'b0;
      ovr_q    <= 1'b0;
      if (bp_wr || !ctrl_en_q) begin
        dma_q <= DMA_IDLE;
        wp_q  <= bp_wr ? pwdata[23:0] : bp_q;
      end else begin
        unique case (dma_q)
          DMA_IDLE: begin
            if (start_q) begin
              desc_q <= wp_q;
              ptr_q  <= ptr_add(wp_q, `MRD_DESC_BYTES, bp_q, rx_buffer_upper_bound_q); // [RULE_15]
              cnt_q  <= 16'h0000;
              drop_q <= flags_q[`MRD_FLG_RX_OVR]; // [RULE_05]
              dma_q  <= DMA_DATA;
            end
          end
          DMA_DATA: begin
            if (byte_vld_q && !drop_q) begin
              mem_we_q <= 1'b1;
              mem_wa_q <= ptr_q[`MRD_MEM_AW-1:0];
              mem_wd_q <= byte_q;
              cnt_q    <= cnt_q + 16'h0001; // [RULE_18]
              if (ptr_nx == rrp_q) begin
                drop_q <= 1'b1;
                ovr_q  <= 1'b1;
              end else begin
                ptr_q <= ptr_nx; // [RULE_14]
              end
            end
            if (end_q) begin
              if (drop_q) begin
                dma_q <= DMA_IDLE; // [RULE_05]
              end else if (np_w == rrp_q) begin
                ovr_q <= 1'b1;
                dma_q <= DMA_IDLE;
              end else begin
                np_q  <= np_w;
                dma_q <= DMA_STAT_LO;
              end
            end
          end
          DMA_STAT_LO: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_addr(4'd5);
            mem_wd_q <= stat_q[7:0]; // [RULE_01] [RULE_22]
            dma_q    <= DMA_STAT_HI;
          end
          DMA_STAT_HI: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_addr(4'd6);
            mem_wd_q <= stat_q[15:8]; // [RULE_01] [RULE_22]
            dma_q    <= DMA_LEN_LO;
          end
          DMA_LEN_LO: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_addr(4'd3);
            mem_wd_q <= cnt_q[7:0]; // [RULE_02] [RULE_16]
            dma_q    <= DMA_LEN_HI;
          end
          DMA_LEN_HI: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_addr(4'd4);
            mem_wd_q <= cnt_q[15:8]; // [RULE_02] [RULE_22]
            dma_q    <= DMA_NP0;
          end
          DMA_NP0: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_q[`MRD_MEM_AW-1:0];
            mem_wd_q <= np_q[7:0]; // [RULE_17] [RULE_22]
            dma_q    <= DMA_NP1;
          end
          DMA_NP1: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_addr(4'd1);
            mem_wd_q <= np_q[15:8]; // [RULE_17]
            dma_q    <= DMA_NP2;
          end
          DMA_NP2: begin
            mem_we_q <= 1'b1;
            mem_wa_q <= desc_addr(4'd2);
            mem_wd_q <= np_q[23:16]; // [RULE_17]
            wp_q     <= np_q;
            done_q   <= 1'b1; // [RULE_02]
            dma_q    <= DMA_IDLE;
          end
        endcase
      end
    end
  end

  // Shared Ethernet memory
  mrd_byte_mem u_mem (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (mem_we_q),
    .waddr (mem_wa_q),
    .wdata (mem_wd_q),
    .raddr (paddr[`MRD_MEM_AW-1:0]),
    .rdata (mem_rd)
  );

  // ----------------------------------------------------------------
  // Transmit and management pins
  // ----------------------------------------------------------------
  // Transmit outputs idle, refreshed only on transmit clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_q <= 1'b0;
      tx_er_q <= 1'b0;
      txd_q   <= 4'h0;
    end else if (tx_rise) begin // [RULE_11]
      tx_en_q <= 1'b0;
      tx_er_q <= 1'b0;
      txd_q   <= 4'h0;
    end
  end

  // Management pins released whenever the MAC is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_o_q  <= 1'b1;
      mdio_oe_q <= 1'b0;
      mdc_o_q   <= 1'b0;
      mdc_oe_q  <= 1'b0;
    end else begin
      mdio_o_q  <= 1'b1;
      mdio_oe_q <= ctrl_en_q; // [RULE_09]
      mdc_o_q   <= 1'b0;
      mdc_oe_q  <= ctrl_en_q; // [RULE_09]
    end
  end

  assign prdata  = prdata_q;
  assign pready  = ready_q;
  assign pslverr = slverr_q;
  assign tx_en   = tx_en_q;
  assign tx_er   = tx_er_q;
  assign txd     = txd_q;
  assign mdio_o  = mdio_o_q;
  assign mdio_oe = mdio_oe_q;
  assign mdc_o   = mdc_o_q;
  assign mdc_oe  = mdc_oe_q;
endmodule
`default_nettype wire

// >>> mrd_rx_dma_sva.sv
// Port checker for the receive DMA block
`default_nettype none
module mrd_rx_dma_chk (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic        tx_en, tx_er, mdio_o, mdio_oe, mdc_o, mdc_oe,
  input wire logic [3:0]  txd
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One wait state, then a single ready cycle
  sequence s_wait; psel && penable && !pready; endsequence
  a_one_wait: assert property (s_wait |=> pready) else $error("ready late");
  a_rdy_pulse: assert property (pready |=> !pready) else $error("ready long");
  a_rdy_req: assert property (pready |-> psel && penable) else $error("ready stray");
  a_win_refuse: assert property (pready && pwrite && paddr[11] |-> pslverr) else $error("window write");
  a_pins_pair: assert property (mdio_oe == mdc_oe) else $error("enables differ");
  a_pins_idle: assert property (mdio_o && !mdc_o) else $error("pin level");
  a_oe_hold: assert property (!psel [*2] |=> $stable(mdio_oe)) else $error("enable moved");
  a_tx_quiet: assert property (!tx_en && !tx_er && txd == 4'h0) else $error("tx active");
endmodule
bind mrd_rx_dma mrd_rx_dma_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
  .paddr, .tx_en, .tx_er, .mdio_o, .mdio_oe, .mdc_o, .mdc_oe, .txd);
`default_nettype wire

// >>> mrd_phy_model.sv
// Transceiver model driving the receive side of the link
`default_nettype none
module mrd_phy_model (
  output var logic       rx_clk, rx_dv, rx_er, tx_clk,
  output var logic [3:0] rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Transmit clock runs free, receive clock only within frames
  initial begin
    {rx_clk, rx_dv, rx_er, rxd, tx_clk} = '0;
    forever #400 tx_clk = ~tx_clk;
  end
  // Preamble, start nibble, then bytes low nibble first
  task automatic send(input int n, input logic [7:0] b0);
    logic [3:0] q[$];
    logic [7:0] b;
    repeat (7) q.push_back(4'h5);
    q.push_back(4'hd);
    for (int i = 0; i < n; i++) begin
      b = b0 + 8'(i);
      q.push_back(b[3:0]);
      q.push_back(b[7:4]);
    end
    foreach (q[k]) begin
      rx_dv = 1'b1;
      rxd = q[k];
      #400 rx_clk = 1'b1;
      #400 rx_clk = 1'b0;
    end
    rx_dv = 1'b0;
    rxd = ~rxd; // No stale nibble after release
    #400 rx_clk = 1'b1; // One idle edge lets the receiver see the frame end
    #400 rx_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> mrd_rx_dma_tb.sv
// Self-checking bench for the receive DMA block
`default_nettype none
module mrd_rx_dma_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_en, tx_er, mdio_o, mdio_oe, mdc_o, mdc_oe, er;
  logic rx_clk, rx_dv, rx_er, tx_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] ev, txd, rxd;
  int n_fail, n_compared;
  mrd_rx_dma uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_clk, .rx_dv, .rx_er, .rxd, .tx_clk, .tx_en, .tx_er, .txd, .mdio_i(mdio_oe ? mdio_o : 1'b1),
    .mdio_o, .mdio_oe, .mdc_o, .mdc_oe, .tx_done_evt(ev[0]), .tx_cf_evt(ev[1]),
    .tx_fsm_err_evt(ev[2]), .mgmt_done_evt(ev[3]));
  mrd_phy_model phy (.rx_clk, .rx_dv, .rx_er, .rxd, .tx_clk);
  task automatic finish_test;
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  // APB transfer: setup, access held until ready, one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    for (i = 0; i < 9 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 9) begin
      n_fail++;
      $display("[ERR] %0t no ready", $time);
      finish_test();
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rv, x);
  endtask
  task automatic t_reset;
    logic [11:0] a[5] = '{12'h008, 12'h00c, 12'h014, 12'h018, 12'h020};
    logic [31:0] x[5] = '{32'h400, 32'h800, 32'h400, 32'h400, 32'h0};
    for (int i = 0; i < 5; i++) rd(a[i], x[i]);
    apb(1'b0, 12'h024, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h800, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_flags;
    logic [7:0] m[4] = '{8'h01, 8'h02, 8'h80, 8'h40};
    for (int i = 0; i < 4; i++) begin
      ev <= 4'h1 << i;
      @(posedge pclk);
      ev <= 4'h0;
      rd(12'h020, {24'h0, m[i]});
      apb(1'b1, 12'h020, {24'h0, m[i]});
      rd(12'h020, 32'h0);
    end
  endtask
  task automatic t_rx;
    logic [7:0] x[8] = '{8'h00, 8'h05, 8'h00, 8'h14, 8'h00, 8'h00, 8'h80, 8'h10};
    apb(1'b1, 12'h000, 32'h1);
    phy.send(20, 8'h10);
    repeat (30) @(posedge pclk);
    rd(12'h020, 32'h28);
    for (int i = 0; i < 8; i++) rd(12'hc00 + 12'(i), {24'h0, x[i]});
  endtask
  task automatic t_ovr;
    apb(1'b1, 12'h020, 32'hff);
    apb(1'b1, 12'h010, 32'hc0);
    apb(1'b1, 12'h014, 32'h520);
    phy.send(40, 8'h20);
    repeat (30) @(posedge pclk);
    rd(12'h01c, 32'h1);
    rd(12'h020, 32'h4);
    apb(1'b1, 12'h014, 32'h400);
    phy.send(4, 8'h30);
    repeat (30) @(posedge pclk);
    rd(12'h018, 32'h500);
    apb(1'b1, 12'h020, 32'hff);
    phy.send(40, 8'h40);
    repeat (30) @(posedge pclk);
    rd(12'h018, 32'h540);
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_flags();
    t_rx();
    t_ovr();
    finish_test();
  end
endmodule
`default_nettype wire
